// File: src/fwp_link.sv
// serial-clock side: command capture and identification answers
`timescale 1ns/1ps
`include "fwp_map.svh"

module fwp_link #(
  parameter logic [7:0] ID_MFR    = 8'ha5,  // arbitrary value
  parameter logic [7:0] ID_DEV_HI = 8'h5a,  // arbitrary value
  parameter logic [7:0] ID_DEV_LO = 8'h3c,  // arbitrary value
  parameter logic [7:0] ID_SHORT  = 8'h42   // arbitrary value
) (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        link_rst_n,
  input  wire logic        dpd_lvl,
  output logic             ev_tgl,
  output logic [7:0]       cmd_op,
  output logic [23:0]      cmd_addr,
  output logic [7:0]       cmd_data,
  output logic             miso,
  output logic             miso_oe
);

  logic [5:0]  bit_cnt_r;
  logic [6:0]  op_lo_r;
  logic [7:0]  op_r;
  logic [31:0] sh_r;
  logic [23:0] id_sh_r;
  logic        id_on_r;
  logic        dpd_s1_r;
  logic        dpd_s2_r;
  logic [31:0] sh_nxt;
  logic [7:0]  cur_op;
  logic        done;

  function automatic logic [5:0] fwp_len(input logic [7:0] op);
    unique case (op)
      `FWP_OP_WRSR1, `FWP_OP_WRSR2:                  fwp_len = `FWP_LEN_STATUS;
      `FWP_OP_PP:                                    fwp_len = `FWP_LEN_PROG;
      `FWP_OP_SE, `FWP_OP_BE32, `FWP_OP_BE64:        fwp_len = `FWP_LEN_ADDR;
      `FWP_OP_ID_JEDEC, `FWP_OP_ID_MD0, `FWP_OP_ID_MD1,
      `FWP_OP_ID_MD2:                                fwp_len = `FWP_LEN_NONE;
      default:                                       fwp_len = `FWP_LEN_SHORT;
    endcase
  endfunction

  assign sh_nxt = {sh_r[30:0], mosi};
  assign cur_op = (bit_cnt_r == 6'd7) ? sh_nxt[7:0] : op_r;
  assign done   = (fwp_len(cur_op) != `FWP_LEN_NONE) && (bit_cnt_r == fwp_len(cur_op) - 6'd1);

  ////////////////////////////////////////////////////////////////////////////
  // frame shifter, cleared by deselect
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_r <= 6'd0;
      sh_r      <= 32'h0;
      op_r      <= 8'h0;
    end
    else
    begin
      sh_r <= sh_nxt;
      if (bit_cnt_r != 6'h3f)
        bit_cnt_r <= bit_cnt_r + 6'd1;
      if (bit_cnt_r == 6'd7)
        op_r <= sh_nxt[7:0];
    end
  end

  // dpd level into serial clock domain
  always_ff @(posedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      dpd_s1_r <= 1'b0;
      dpd_s2_r <= 1'b0;
    end
    else
    begin
      dpd_s1_r <= dpd_lvl;
      dpd_s2_r <= dpd_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // identification answers
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      id_sh_r <= 24'h0;
      id_on_r <= 1'b0;
    end
    else if (bit_cnt_r == 6'd7)
    begin
      unique case (sh_nxt[7:0])
        `FWP_OP_ID_JEDEC:
        begin
          id_sh_r <= {ID_MFR, ID_DEV_HI, ID_DEV_LO};
          id_on_r <= !dpd_s2_r;
        end
        `FWP_OP_ID_MD0, `FWP_OP_ID_MD1, `FWP_OP_ID_MD2:
        begin
          id_sh_r <= {ID_MFR, ID_SHORT, 8'h00};
          id_on_r <= !dpd_s2_r;
        end
        `FWP_OP_DPD_REL:
        begin
          id_sh_r <= {ID_SHORT, 16'h0000};
          id_on_r <= 1'b1;
        end
        default:
        begin
          id_sh_r <= 24'h0;
          id_on_r <= 1'b0;
        end
      endcase
    end
    else if (id_on_r)
      id_sh_r <= {id_sh_r[22:0], 1'b0};
  end

  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      miso    <= id_sh_r[23];
      miso_oe <= id_on_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completed command: payload and event toggle on the same sck edge
  always_ff @(posedge sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
      ev_tgl <= 1'b0;
    else if (!cs_n && done)
      ev_tgl <= ~ev_tgl;
  end

  always_ff @(posedge sck)
  begin
    if (!cs_n && done)
    begin
      cmd_op <= cur_op;
      if (bit_cnt_r == `FWP_LEN_PROG - 6'd1)
      begin
        cmd_addr <= sh_nxt[31:8];
        cmd_data <= sh_nxt[7:0];
      end
      else
      begin
        cmd_addr <= sh_nxt[23:0];
        cmd_data <= sh_nxt[7:0];
      end
    end
  end

endmodule // fwp_link

// File: src/fwp_map.svh
// register offsets, field positions, opcodes and array constants
`ifndef FWP_MAP_SVH
`define FWP_MAP_SVH

`define FWP_AXI_AW        5
`define FWP_REG_STATUS    5'h00
`define FWP_REG_CTRL      5'h04
`define FWP_REG_RANGE_LO  5'h08
`define FWP_REG_RANGE_HI  5'h0c

`define FWP_ST_WEL        0
`define FWP_ST_BP_LSB     1
`define FWP_ST_SRP_LO     6
`define FWP_ST_SRP_HI     7
`define FWP_ST_CMP        8
`define FWP_ST_DPD        9
`define FWP_ST_WP         10
`define FWP_ST_RST_EN     11
`define FWP_CTRL_PWR_CYC  0
`define FWP_RANGE_NONE    24

`define FWP_RESP_OKAY     2'h0
`define FWP_RESP_DECERR   2'h3

`define FWP_OP_WREN       8'h06
`define FWP_OP_WRDI       8'h04
`define FWP_OP_WRSR1      8'h01
`define FWP_OP_WRSR2      8'h31
`define FWP_OP_PP         8'h02
`define FWP_OP_SE         8'h20
`define FWP_OP_BE32       8'h52
`define FWP_OP_BE64       8'hd8
`define FWP_OP_CE1        8'hc7
`define FWP_OP_CE2        8'h60
`define FWP_OP_RST_EN     8'h66
`define FWP_OP_RST        8'h99
`define FWP_OP_DPD        8'hb9
`define FWP_OP_DPD_REL    8'hab
`define FWP_OP_ID_JEDEC   8'h9f
`define FWP_OP_ID_MD0     8'h90
`define FWP_OP_ID_MD1     8'h92
`define FWP_OP_ID_MD2     8'h94

`define FWP_LEN_SHORT     6'd8
`define FWP_LEN_STATUS    6'd16
`define FWP_LEN_ADDR      6'd32
`define FWP_LEN_PROG      6'd40
`define FWP_LEN_NONE      6'd0

`define FWP_ARRAY_BYTES   25'h1000000
`define FWP_TOP_UNIT      25'h0020000
`define FWP_SECT_UNIT     25'h0000800
`define FWP_SECT_MAX      25'h0008000
`define FWP_MASK_PAGE     24'h0000ff
`define FWP_MASK_SECT     24'h000fff
`define FWP_MASK_BLK32    24'h007fff
`define FWP_MASK_BLK64    24'h00ffff
`define FWP_MASK_CHIP     24'hffffff

`endif

// File: src/fwp_pkg.sv
// types shared by the write-protect block
package fwp_pkg;

  typedef enum logic [2:0] {
    FWP_K_PAGE   = 3'h0,
    FWP_K_SECT   = 3'h1,
    FWP_K_BLK32  = 3'h2,
    FWP_K_BLK64  = 3'h3,
    FWP_K_CHIP   = 3'h4
  } fwp_kind_t;

  typedef enum logic [1:0] {
    FWP_WS_IDLE  = 2'h0,
    FWP_WS_RESP  = 2'h1
  } fwp_wstate_t;

endpackage

// File: src/fwp_top.sv
// flash write-protect logic: status protection, latch, range decode, register slave
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "fwp_map.svh"

module fwp_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic [`FWP_AXI_AW-1:0]  awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [`FWP_AXI_AW-1:0]  araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    sck,
  input  wire logic                    cs_n,
  input  wire logic                    mosi,
  output logic                         miso,
  output logic                         miso_oe,
  input  wire logic                    wp_n,
  output logic                         exec_valid,
  output fwp_pkg::fwp_kind_t           exec_kind,
  output logic [23:0]                  exec_addr,
  output logic                         reject
);

  logic        ev_tgl;
  logic [7:0]  cmd_op;
  logic [23:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic        ev_s1_r;
  logic        ev_s2_r;
  logic        ev_s3_r;
  logic        wp_s1_r;
  logic        wp_s2_r;
  logic        srp_hi_r;
  logic        srp_lo_r;
  logic [4:0]  bp_r;
  logic        cmp_r;
  logic        wel_r;
  logic        dpd_r;
  logic        rst_en_r;
  logic        pwr_cyc;
  logic        ev;
  logic        cmd_ok;
  logic        srp_ok;
  logic        is_wrsr;
  logic        is_arr;
  logic        arr_hit;
  logic        arr_ok;
  logic [48:0] base;
  logic [23:0] span_lo;
  logic [23:0] span_hi;
  logic [23:0] mask;
  logic        chip_ok;
  fwp_pkg::fwp_kind_t kind;

  fwp_pkg::fwp_wstate_t ws_r;
  logic                 aw_got_r;
  logic                 w_got_r;
  logic [`FWP_AXI_AW-1:0] awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;

  ////////////////////////////////////////////////////////////////////////////
  // serial-clock side
  fwp_link u_link (
    .sck        (sck),
    .cs_n       (cs_n),
    .mosi       (mosi),
    .link_rst_n (aresetn),
    .dpd_lvl    (dpd_r),
    .ev_tgl     (ev_tgl),
    .cmd_op     (cmd_op),
    .cmd_addr   (cmd_addr),
    .cmd_data   (cmd_data),
    .miso       (miso),
    .miso_oe    (miso_oe)
  );

  // event toggle and protect pin into aclk domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
      wp_s1_r <= 1'b0;
      wp_s2_r <= 1'b0;
    end
    else if (ce)
    begin
      ev_s1_r <= ev_tgl;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
    end
  end

  assign ev     = ev_s2_r ^ ev_s3_r;
  assign cmd_ok = ev && (!dpd_r || cmd_op == `FWP_OP_DPD_REL);

  ////////////////////////////////////////////////////////////////////////////
  // protected range decode: {none, lo, hi} with complement clear
  function automatic logic [48:0] fwp_base(input logic [4:0] bp);
    logic [24:0] size;
    logic [23:0] lo;
    logic        none;
    size = 25'h0;
    lo   = 24'h0;
    none = 1'b0;
    if (bp[2:0] == 3'h0)
      none = 1'b1;
    else if (bp[2:0] == 3'h7)
      size = `FWP_ARRAY_BYTES;
    else if (!bp[4])
      size = `FWP_TOP_UNIT << bp[2:0];
    else if (bp[2])
      size = `FWP_SECT_MAX;
    else
      size = `FWP_SECT_UNIT << bp[2:0];
    if (!bp[3])
      lo = 24'(`FWP_ARRAY_BYTES - size);
    fwp_base = {none, lo, 24'(25'(lo) + size - 25'h1)};
  endfunction

  // register index from a byte address, 3'h7 for unmapped
  function automatic logic [2:0] fwp_dec(input logic [`FWP_AXI_AW-1:0] a);
    unique case (a)
      `FWP_REG_STATUS:   fwp_dec = 3'h0;
      `FWP_REG_CTRL:     fwp_dec = 3'h1;
      `FWP_REG_RANGE_LO: fwp_dec = 3'h2;
      `FWP_REG_RANGE_HI: fwp_dec = 3'h3;
      default:           fwp_dec = 3'h7;
    endcase
  endfunction

  assign base = fwp_base(bp_r);

  always_comb
  begin
    kind = fwp_pkg::FWP_K_PAGE;
    mask = `FWP_MASK_PAGE;
    is_arr = 1'b1;
    unique case (cmd_op)
      `FWP_OP_PP:   ;
      `FWP_OP_SE:
      begin
        kind = fwp_pkg::FWP_K_SECT;
        mask = `FWP_MASK_SECT;
      end
      `FWP_OP_BE32:
      begin
        kind = fwp_pkg::FWP_K_BLK32;
        mask = `FWP_MASK_BLK32;
      end
      `FWP_OP_BE64:
      begin
        kind = fwp_pkg::FWP_K_BLK64;
        mask = `FWP_MASK_BLK64;
      end
      `FWP_OP_CE1, `FWP_OP_CE2:
      begin
        kind = fwp_pkg::FWP_K_CHIP;
        mask = `FWP_MASK_CHIP;
      end
      default: is_arr = 1'b0;
    endcase
  end

  assign span_lo = cmd_addr & ~mask;
  assign span_hi = cmd_addr | mask;

  always_comb
  begin
    if (!cmp_r)
      arr_hit = !base[48] && span_lo <= base[23:0] && span_hi >= base[47:24];
    else
      arr_hit = base[48] || span_lo < base[47:24] || span_hi > base[23:0];
  end

  assign chip_ok = (bp_r[2:0] == 3'h0 && !cmp_r) || (bp_r[2:0] == 3'h7 && cmp_r);
  assign arr_ok  = wel_r && (kind == fwp_pkg::FWP_K_CHIP ? chip_ok : !arr_hit);
  assign is_wrsr = cmd_op == `FWP_OP_WRSR1 || cmd_op == `FWP_OP_WRSR2;

  always_comb
  begin
    unique case ({srp_hi_r, srp_lo_r})
      2'b00:   srp_ok = 1'b1;
      2'b01:   srp_ok = wp_s2_r;
      2'b10:   srp_ok = 1'b0;
      2'b11:   srp_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write enable latch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wel_r <= 1'b0;
    else if (ce)
    begin
      if (cmd_ok && cmd_op == `FWP_OP_WREN)
        wel_r <= 1'b1;
      else if (pwr_cyc)
        wel_r <= 1'b0;
      else if (cmd_ok && (cmd_op == `FWP_OP_WRDI || is_wrsr || is_arr))
        wel_r <= 1'b0;
      else if (cmd_ok && cmd_op == `FWP_OP_RST && rst_en_r)
        wel_r <= 1'b0;
    end
  end

  // status protect mode, block protect, complement
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      srp_hi_r <= 1'b0;
      srp_lo_r <= 1'b0;
      bp_r     <= 5'h0;
      cmp_r    <= 1'b0;
    end
    else if (ce)
    begin
      if (pwr_cyc && srp_hi_r && !srp_lo_r)
        srp_hi_r <= 1'b0;
      else if (cmd_ok && is_wrsr && wel_r && srp_ok)
      begin
        if (cmd_op == `FWP_OP_WRSR1)
        begin
          srp_lo_r <= cmd_data[7];
          bp_r     <= cmd_data[6:2];
        end
        else
        begin
          cmp_r    <= cmd_data[6];
          srp_hi_r <= cmd_data[0];
        end
      end
    end
  end

  // deep power-down and reset arming
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dpd_r    <= 1'b0;
      rst_en_r <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_ok && cmd_op == `FWP_OP_DPD)
        dpd_r <= 1'b1;
      else if (pwr_cyc || (cmd_ok && cmd_op == `FWP_OP_DPD_REL))
        dpd_r <= 1'b0;
      if (cmd_ok)
        rst_en_r <= (cmd_op == `FWP_OP_RST_EN);
      else if (pwr_cyc)
        rst_en_r <= 1'b0;
    end
  end

  // array command result and status write reject
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exec_valid <= 1'b0;
      exec_kind  <= fwp_pkg::FWP_K_PAGE;
      exec_addr  <= 24'h0;
      reject     <= 1'b0;
    end
    else if (ce)
    begin
      exec_valid <= cmd_ok && is_arr && arr_ok;
      reject     <= cmd_ok && ((is_arr && !arr_ok) || (is_wrsr && !(wel_r && srp_ok)));
      if (cmd_ok && is_arr)
      begin
        exec_kind <= kind;
        exec_addr <= cmd_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave: write channel
  assign pwr_cyc = ws_r == fwp_pkg::FWP_WS_IDLE && aw_got_r && w_got_r
                   && fwp_dec(awaddr_r) == 3'h1 && wstrb_r[0]
                   && wdata_r[`FWP_CTRL_PWR_CYC];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_r     <= fwp_pkg::FWP_WS_IDLE;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `FWP_RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
        awready  <= 1'b0;
      end
      else if (ws_r == fwp_pkg::FWP_WS_IDLE && !aw_got_r)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
        wready  <= 1'b0;
      end
      else if (ws_r == fwp_pkg::FWP_WS_IDLE && !w_got_r)
        wready <= 1'b1;
      unique case (ws_r)
        fwp_pkg::FWP_WS_IDLE:
          if (aw_got_r && w_got_r)
          begin
            ws_r     <= fwp_pkg::FWP_WS_RESP;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= fwp_dec(awaddr_r) == 3'h7 ? `FWP_RESP_DECERR : `FWP_RESP_OKAY;
          end
        fwp_pkg::FWP_WS_RESP:
          if (bready)
          begin
            ws_r   <= fwp_pkg::FWP_WS_IDLE;
            bvalid <= 1'b0;
          end
      endcase
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `FWP_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `FWP_RESP_OKAY;
        rdata   <= 32'h0;
        unique case (fwp_dec(araddr))
          3'h0:
          begin
            rdata[`FWP_ST_WEL]                    <= wel_r;
            rdata[`FWP_ST_BP_LSB+4:`FWP_ST_BP_LSB] <= bp_r;
            rdata[`FWP_ST_SRP_LO]                 <= srp_lo_r;
            rdata[`FWP_ST_SRP_HI]                 <= srp_hi_r;
            rdata[`FWP_ST_CMP]                    <= cmp_r;
            rdata[`FWP_ST_DPD]                    <= dpd_r;
            rdata[`FWP_ST_WP]                     <= wp_s2_r;
            rdata[`FWP_ST_RST_EN]                 <= rst_en_r;
          end
          3'h2:
          begin
            rdata[23:0]             <= base[47:24];
            rdata[`FWP_RANGE_NONE]  <= base[48];
          end
          3'h3:
          begin
            rdata[23:0]             <= base[23:0];
            rdata[`FWP_RANGE_NONE]  <= base[48];
          end
          3'h7:    rresp <= `FWP_RESP_DECERR;
          default: ;
        endcase
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
      else if (!rvalid)
        arready <= 1'b1;
    end
  end

endmodule // fwp_top

// File: verif/fwp_host.sv
// spi host model sending command frames
`timescale 1ns/1ps

module fwp_host (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic [39:0] rx;
  initial
  begin
    sck = '0;
    cs_n <= '1; // deferred so the link sees the deselect edge
    mosi = '0;
    rx = '0;
  end
  // mode 0, msb first, clock only inside the frame
  task automatic xfer(input logic [39:0] f, input int n);
    cs_n = '0;
    #5;
    for (int i = 0; i < n; i++)
    begin
      mosi = f[39-i];
      #3 sck = '1;
      rx = {rx[38:0], miso_oe ? miso : 1'h0};
      #3 sck = '0;
    end
    #5 cs_n = '1;
    mosi = ~mosi;
  endtask
endmodule // fwp_host

// File: verif/fwp_props.sv
// assertions on the write-protect block ports
`timescale 1ns/1ps

module fwp_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic exec_valid,
  input wire logic reject
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  AST_ONE_OUTCOME: assert property (!(exec_valid && reject))
    else $error("exec and reject together");
  AST_EXEC_PULSE: assert property (exec_valid |=> !exec_valid)
    else $error("exec pulse too long");
  AST_REJ_PULSE: assert property (reject |=> !reject)
    else $error("reject pulse too long");
  AST_ID_QUIET: assert property (cs_n [*3] |-> !miso_oe)
    else $error("id driver on while deselected");
  AST_OE_SEL: assert property (miso_oe |-> !cs_n)
    else $error("id driver without select");
  AST_B_ANS: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write response");
  AST_R_ANS: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("no read data");
  AST_B_BUSY: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response held");
  AST_R_BUSY: assert property (rvalid |-> !arready)
    else $error("read taken while data held");
  ////////////////////////////////////////////////////////////////////////////
  cover property (exec_valid);
  cover property (reject);
  cover property ($rose(miso_oe));
endmodule // fwp_props

bind fwp_top fwp_props u_props (.*);

// File: verif/tb.sv
// self-checking bench for the write-protect block
`timescale 1ns/1ps
`include "fwp_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end

module tb;
  logic aclk = '0, aresetn = '1, ce = '1, awvalid = '0, wvalid = '0, bready = '0;
  logic arvalid = '0, rready = '0, wp_n = '1;
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, d;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  r;
  wire         sck, cs_n, mosi, miso, miso_oe, awready, wready, bvalid, arready;
  wire         rvalid, exec_valid, reject;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [23:0] exec_addr;
  fwp_pkg::fwp_kind_t exec_kind;
  int          err_count = 0, num_checks = 0, n_ex = 0, n_rj = 0;
  logic [52:0] tbl [5] = '{{5'h09, 24'h0, 24'h03ffff}, {5'h11, 24'hfff000, 24'hffffff},
    {5'h1c, 24'h0, 24'h007fff}, {5'h07, 24'h0, 24'hffffff}, {5'h01, 24'hfc0000, 24'hffffff}};
  fwp_top u_dut (.*);
  fwp_host u_host (.sck, .cs_n, .mosi, .miso, .miso_oe);
  initial forever #10 aclk = ~aclk;
  always @(posedge aclk)
  begin
    n_ex += int'(exec_valid === 1'h1);
    n_rj += int'(reject === 1'h1);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= '1;
    wvalid <= '1;
    bready <= '1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= '0;
      if (wready) wvalid <= '0;
      r = bresp;
    end
    while (bvalid !== 1'h1);
    bready <= '0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= '1;
    rready <= '1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= '0;
      d = rdata;
      r = rresp;
    end
    while (rvalid !== 1'h1);
    rready <= '0;
  endtask
  task automatic st(input logic [11:0] m, input logic [11:0] e);
    rd(`FWP_REG_STATUS);
    `CHK(d[11:0] & m, e)
  endtask
  task automatic cmd(input logic [39:0] f, input int n, input int ex, input int rj);
    int e0;
    int r0;
    e0 = n_ex;
    r0 = n_rj;
    u_host.xfer(f, n);
    repeat (10) @(posedge aclk);
    `CHK(n_ex - e0, ex)
    `CHK(n_rj - r0, rj)
  endtask
  task automatic sr(input logic [7:0] op, input logic [7:0] b, input int rj);
    cmd({`FWP_OP_WREN, 32'h0}, 8, 0, 0);
    cmd({op, b, 24'h0}, 16, 0, rj);
  endtask
  task automatic ar(input logic [7:0] op, input logic [23:0] a, input int n, input int ex);
    cmd({`FWP_OP_WREN, 32'h0}, 8, 0, 0);
    cmd({op, a, 8'h0}, n, ex, 1 - ex);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #300us;
    err_count++;
    complete_run();
  end
  initial
  begin
    aresetn <= '0; // deferred so the async link reset sees an edge
    repeat (3) @(posedge aclk);
    aresetn <= '1;
    repeat (3) @(posedge aclk);
    st(12'h3ff, 12'h0);
    rd(5'h10);
    `CHK(r, `FWP_RESP_DECERR)
    rd(`FWP_REG_RANGE_LO);
    `CHK(d[24], 1'h1)
    foreach (tbl[i])
    begin
      sr(`FWP_OP_WRSR1, {1'h0, tbl[i][52:48], 2'h0}, 0);
      rd(`FWP_REG_RANGE_LO);
      `CHK(d[24:0], {1'h0, tbl[i][47:24]})
      rd(`FWP_REG_RANGE_HI);
      `CHK(d[24:0], {1'h0, tbl[i][23:0]})
    end
    $display("test range done");
    ar(`FWP_OP_SE, 24'hffc000, 32, 0);
    ar(`FWP_OP_SE, 24'hfb0000, 32, 1);
    `CHK(exec_kind, fwp_pkg::FWP_K_SECT)
    `CHK(exec_addr, 24'hfb0000)
    ar(`FWP_OP_BE32, 24'h008000, 32, 1);
    `CHK(exec_kind, fwp_pkg::FWP_K_BLK32)
    ar(`FWP_OP_CE1, 24'h0, 8, 0);
    cmd({`FWP_OP_PP, 32'h0}, 40, 0, 1);
    sr(`FWP_OP_WRSR2, 8'h40, 0);
    st(12'h101, 12'h100);
    ar(`FWP_OP_SE, 24'hfb0000, 32, 0);
    ar(`FWP_OP_BE64, 24'hfc0000, 32, 1);
    `CHK(exec_kind, fwp_pkg::FWP_K_BLK64)
    sr(`FWP_OP_WRSR1, 8'h1c, 0);
    ar(`FWP_OP_CE2, 24'h0, 8, 1);
    `CHK(exec_kind, fwp_pkg::FWP_K_CHIP)
    sr(`FWP_OP_WRSR2, 8'h00, 0);
    $display("test array done");
    cmd({`FWP_OP_WREN, 32'h0}, 8, 0, 0);
    st(12'h001, 12'h001);
    cmd({`FWP_OP_WRDI, 32'h0}, 8, 0, 0);
    st(12'h001, 12'h000);
    sr(`FWP_OP_WRSR1, 8'h80, 0);
    wp_n <= '0;
    sr(`FWP_OP_WRSR1, 8'h04, 1);
    st(12'h07f, 12'h040);
    wp_n <= '1;
    sr(`FWP_OP_WRSR1, 8'h00, 0);
    st(12'h040, 12'h000);
    sr(`FWP_OP_WRSR2, 8'h01, 0);
    st(12'h0c0, 12'h080);
    sr(`FWP_OP_WRSR1, 8'h04, 1);
    wr(`FWP_REG_CTRL, 32'h1);
    `CHK(r, `FWP_RESP_OKAY)
    st(12'h0ff, 12'h000);
    wr(5'h14, 32'h1);
    `CHK(r, `FWP_RESP_DECERR)
    cmd({`FWP_OP_WREN, 32'h0}, 8, 0, 0);
    cmd({`FWP_OP_RST_EN, 32'h0}, 8, 0, 0);
    st(12'h801, 12'h801);
    cmd({`FWP_OP_RST, 32'h0}, 8, 0, 0);
    st(12'h801, 12'h000);
    $display("test status done");
    cmd({`FWP_OP_DPD, 32'h0}, 8, 0, 0);
    st(12'h200, 12'h200);
    cmd({`FWP_OP_ID_JEDEC, 32'h0}, 32, 0, 0);
    `CHK(u_host.rx[23:0], 24'h0)
    cmd({`FWP_OP_WREN, 32'h0}, 8, 0, 0);
    cmd({`FWP_OP_PP, 32'h0}, 40, 0, 0);
    st(12'h001, 12'h000);
    cmd({`FWP_OP_DPD_REL, 32'h0}, 16, 0, 0);
    `CHK(u_host.rx[7:0], 8'h42)
    st(12'h200, 12'h000);
    cmd({`FWP_OP_ID_JEDEC, 32'h0}, 32, 0, 0);
    `CHK(u_host.rx[23:0], 24'ha55a3c)
    foreach (tbl[i])
    begin
      if (i < 3)
      begin
        cmd({8'h90 + 8'(2 * i), 32'h0}, 24, 0, 0);
        `CHK(u_host.rx[15:0], 16'ha542)
      end
    end
    $display("test power and id done");
    complete_run();
  end
endmodule // tb
